// ### logic/irm_pkg.sv
/*
 Constants for the ingress rate meter table: register indices, command
 fields, reset values and byte timing.
 Assumes a 100 MHz pclk; APB byte address is four times a register index.
*/
`default_nettype none
package irm_pkg;
  // ==========================================================
  // Table shape
  localparam int        ENTRIES    = 24;
  localparam int        DW         = 16;
  localparam int        IDXW       = 5;
  localparam logic [4:0] ENTRIES_5 = 5'h18;
  // ==========================================================
  // Register indices (byte address = index * 4)
  localparam logic [13:0] IDX_CFG   = 14'h184a;
  localparam logic [13:0] IDX_CMD   = 14'h184b;
  localparam logic [13:0] IDX_STS   = 14'h184c;
  localparam logic [13:0] IDX_WDATA = 14'h184d;
  localparam logic [13:0] IDX_RDATA = 14'h184e;
  // ==========================================================
  // Fields
  localparam int         CFG_EN_BIT   = 0;
  localparam int         STS_PEND_BIT = 0;
  localparam int         CMD_DIR_BIT  = 7;
  localparam int         CMD_TGT_LO   = 5;
  localparam int         CMD_W        = 8;
  localparam logic [1:0] TGT_RATE     = 2'h1;
  localparam logic [1:0] TGT_CBS      = 2'h2;
  localparam logic [1:0] TGT_EBS      = 2'h3;
  // ==========================================================
  // Reset values
  localparam logic [15:0] BURST_RST = 16'h0600;
  localparam logic [15:0] RATE_RST  = 16'h0014;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  // ==========================================================
  // Byte time unit
  localparam int        BYTE_TIME_NS = 20;
  localparam int        CLK_NS       = 10;
  localparam int        TICK_CYC     =
    (BYTE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] TICK_LAST   = 8'(TICK_CYC - 1);

  typedef enum logic [0:0] {
    CMD_IDLE = 1'b0,
    CMD_BUSY = 1'b1
  } irm_cmd_e;
endpackage
`default_nettype wire

// ### logic/irm_rate_meter.sv
/*
 Ingress rate meter table: APB register slave, indirect table access,
 per-entry token buckets and per-packet drop verdicts.
 Assumes packet requests are synchronous to pclk, one per cycle at most.
*/
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1 - Excess burst limit register holds max excess burst bytes, resets 0600h.
// R2 - Over excess burst and over excess rate: packet dropped outright.
// R3 - Committed burst limit register holds max committed bytes, resets 0600h.
// R4 - Over committed burst and rate: random drop, not certain drop.
// R5 - Software keeps one burst limit at least the largest packet.
// R6 - Every bucket starts full at 0600h after reset.
// R7 - Lowered limit only caps a bucket after traffic drains it below.
// R8 - Rate entry gives (value+1) x 20 ns per byte; resets 0014h.
// R9 - Twenty-four 16-bit rate entries, one per port and priority.
// R10 - Both burst limit registers are 16 bits wide.
// R11 - Status bit 0 is pending while a table command runs; resets 0.
// R12 - Pending clears by itself when the command completes.
// R13 - Write data bits 15:0 feed table writes; resets 0; upper read 0.
// R14 - Writing the command register launches the access it describes.
// R15 - Command bit 7: one reads the table, zero writes it.
// R16 - Target 01 rate entry by index, 10 committed, 11 excess, 00 none.
// R17 - After a read command, read data shows the selected value.
// R18 - Command written while pending is ignored; running one completes.
module irm_rate_meter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        pkt_valid,
  input  wire logic [4:0]  pkt_entry,
  input  wire logic [15:0] pkt_len,
  output var  logic        verdict_valid,
  output var  logic        verdict_drop,
  output var  logic        verdict_random,
  output var  logic        table_pending
);
  // ==========================================================
  // State
  typedef struct packed {
    irm_pkg::irm_cmd_e       cst;
    logic [7:0]              cmd;
    logic [15:0]             wdata;
    logic [15:0]             rdata;
    logic [15:0]             cbs;
    logic [15:0]             ebs;
    logic                    en;
    logic [23:0][15:0]       rate;
    logic [23:0][15:0]       cbkt;
    logic [23:0][15:0]       ebkt;
    logic [23:0][15:0]       cnt;
    logic [7:0]              div;
    logic                    tick;
    logic [15:0]             lfsr;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    vvalid;
    logic                    vdrop;
    logic                    vrand;
  } irm_state_s;

  irm_state_s st_q;
  irm_state_s st_d;

  function automatic logic entry_ok(input logic [4:0] e);
    entry_ok = e < irm_pkg::ENTRIES_5;
  endfunction

  logic [13:0] idx;
  logic        wr_acc;
  logic [1:0]  tgt;
  logic [4:0]  eidx;
  logic [15:0] cbkt_pkt;
  logic [15:0] ebkt_pkt;

  assign idx    = paddr[15:2];
  assign wr_acc = psel && penable && pwrite && st_q.pready;
  assign tgt    = st_q.cmd[irm_pkg::CMD_TGT_LO +: 2];
  assign eidx   = st_q.cmd[irm_pkg::IDXW-1:0];
  assign cbkt_pkt = entry_ok(pkt_entry) ? st_q.cbkt[pkt_entry] : '0;
  assign ebkt_pkt = entry_ok(pkt_entry) ? st_q.ebkt[pkt_entry] : '0;

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.vvalid = 1'b0;
    st_d.vdrop = 1'b0;
    st_d.vrand = 1'b0;
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    st_d.tick = 1'b0;

    // One byte-time enable every 20 ns
    if (st_q.div == irm_pkg::TICK_LAST) begin
      st_d.div = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.div = st_q.div + 8'h1;
    end

    // Refill: one token per (value+1) byte times
    for (int i = 0; i < irm_pkg::ENTRIES; i++) begin
      if (st_q.tick) begin
        if (st_q.cnt[i] >= st_q.rate[i]) begin // R8
          st_d.cnt[i] = '0;
          // Never clamps down: a lowered limit waits for drain
          if (st_q.cbkt[i] < st_q.cbs) // R7 R3
            st_d.cbkt[i] = st_q.cbkt[i] + 16'h1;
          if (st_q.ebkt[i] < st_q.ebs) // R7 R1
            st_d.ebkt[i] = st_q.ebkt[i] + 16'h1;
        end else begin
          st_d.cnt[i] = st_q.cnt[i] + 16'h1;
        end
      end
    end

    st_d.lfsr = {1'b0, st_q.lfsr[15:1]} ^
                (st_q.lfsr[0] ? irm_pkg::LFSR_TAPS : 16'h0);

    // Packet verdict; bad index or metering off passes
    if (pkt_valid) begin
      st_d.vvalid = 1'b1;
      if (st_q.en && entry_ok(pkt_entry)) begin
        if (st_d.cbkt[pkt_entry] >= pkt_len) begin
          st_d.cbkt[pkt_entry] = st_d.cbkt[pkt_entry] - pkt_len;
        end else if (st_d.ebkt[pkt_entry] >= pkt_len) begin
          st_d.vrand = 1'b1; // R4
          st_d.vdrop = st_q.lfsr[0]; // R4
          if (!st_q.lfsr[0])
            st_d.ebkt[pkt_entry] = st_d.ebkt[pkt_entry] - pkt_len;
        end else begin
          st_d.vdrop = 1'b1; // R2
        end
      end
    end

    // APB: no wait state; read data built at setup leaves a flop with pready
    if (psel && !penable) begin
      st_d.pready = 1'b1;
      st_d.prdata = '0;
      unique case (idx)
        irm_pkg::IDX_CFG:
          st_d.prdata[irm_pkg::CFG_EN_BIT] = st_q.en;
        irm_pkg::IDX_CMD:
          st_d.prdata[irm_pkg::CMD_W-1:0] = st_q.cmd;
        irm_pkg::IDX_STS: // R11
          st_d.prdata[irm_pkg::STS_PEND_BIT] =
            (st_q.cst == irm_pkg::CMD_BUSY);
        irm_pkg::IDX_WDATA:
          st_d.prdata[irm_pkg::DW-1:0] = st_q.wdata; // R13
        irm_pkg::IDX_RDATA:
          st_d.prdata[irm_pkg::DW-1:0] = st_q.rdata; // R17
        default:
          st_d.pslverr = 1'b1;
      endcase
    end

    if (wr_acc) begin
      if (idx == irm_pkg::IDX_CFG)
        st_d.en = pwdata[irm_pkg::CFG_EN_BIT];
      if (idx == irm_pkg::IDX_WDATA)
        st_d.wdata = pwdata[irm_pkg::DW-1:0]; // R13
    end

    // Table command engine
    unique case (st_q.cst)
      irm_pkg::CMD_IDLE: begin
        if (wr_acc && idx == irm_pkg::IDX_CMD) begin
          st_d.cmd = pwdata[irm_pkg::CMD_W-1:0]; // R14
          st_d.cst = irm_pkg::CMD_BUSY; // R11
        end
      end
      irm_pkg::CMD_BUSY: begin
        // Late command writes fall here and are dropped
        st_d.cst = irm_pkg::CMD_IDLE; // R12 R18
        if (st_q.cmd[irm_pkg::CMD_DIR_BIT]) begin // R15
          st_d.rdata = '0;
          unique case (tgt) // R16
            irm_pkg::TGT_RATE:
              if (entry_ok(eidx))
                st_d.rdata = st_q.rate[eidx]; // R17
            irm_pkg::TGT_CBS: st_d.rdata = st_q.cbs;
            irm_pkg::TGT_EBS: st_d.rdata = st_q.ebs;
            default: st_d.rdata = '0;
          endcase
        end else begin
          // Burst writes leave buckets alone
          unique case (tgt) // R16
            irm_pkg::TGT_RATE:
              if (entry_ok(eidx))
                st_d.rate[eidx] = st_q.wdata; // R9
            irm_pkg::TGT_CBS: st_d.cbs = st_q.wdata; // R10
            irm_pkg::TGT_EBS: st_d.ebs = st_q.wdata; // R10
            default: st_d.cbs = st_q.cbs;
          endcase
        end
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.cbs <= irm_pkg::BURST_RST; // R3
      st_q.ebs <= irm_pkg::BURST_RST; // R1
      st_q.lfsr <= irm_pkg::LFSR_SEED;
      for (int i = 0; i < irm_pkg::ENTRIES; i++) begin
        st_q.rate[i] <= irm_pkg::RATE_RST; // R8
        st_q.cbkt[i] <= irm_pkg::BURST_RST; // R6
        st_q.ebkt[i] <= irm_pkg::BURST_RST; // R6
      end
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata         = st_q.prdata;
  assign pready         = st_q.pready;
  assign pslverr        = st_q.pslverr;
  assign verdict_valid  = st_q.vvalid;
  assign verdict_drop   = st_q.vdrop;
  assign verdict_random = st_q.vrand;
  assign table_pending  = (st_q.cst == irm_pkg::CMD_BUSY);

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic cmd_wr;
  assign cmd_wr = wr_acc && idx == irm_pkg::IDX_CMD;

  AST_PEND_SETS: assert property ( // R14
    cmd_wr && !table_pending |=> table_pending)
    else $error("command write did not raise pending");
  AST_PEND_CLEARS: assert property ( // R12
    table_pending |=> !table_pending)
    else $error("pending did not clear after one cycle");
  AST_BUSY_IGNORED: assert property ( // R18
    cmd_wr && table_pending |=> $stable(st_q.cmd))
    else $error("command changed while pending");
  AST_BUCKET_CAP: assert property ( // R7
    st_q.cbkt[0] > $past(st_q.cbkt[0]) |->
      $past(st_q.cbkt[0]) < $past(st_q.cbs))
    else $error("bucket grew past its limit");
  AST_HARD_DROP: assert property ( // R2
    verdict_valid && verdict_drop && !verdict_random |->
      $past(pkt_len) > $past(ebkt_pkt))
    else $error("hard drop with enough excess tokens");
  AST_RANDOM: assert property ( // R4
    verdict_random |-> $past(pkt_len) > $past(cbkt_pkt))
    else $error("random drop with enough committed tokens");
  AST_TICK: assert property ( // R8
    st_q.tick |=> !st_q.tick ##1 st_q.tick)
    else $error("byte time is not two cycles");
  AST_READ_CBS: assert property ( // R17
    table_pending && st_q.cmd[irm_pkg::CMD_DIR_BIT] &&
      tgt == irm_pkg::TGT_CBS |=> st_q.rdata == $past(st_q.cbs))
    else $error("read data not committed burst limit");
  AST_WRITE_EBS: assert property ( // R13
    table_pending && !st_q.cmd[irm_pkg::CMD_DIR_BIT] &&
      tgt == irm_pkg::TGT_EBS |=> st_q.ebs == $past(st_q.wdata))
    else $error("excess burst limit not written");
  AST_WRITE_CBS: assert property ( // R10
    table_pending && !st_q.cmd[irm_pkg::CMD_DIR_BIT] &&
      tgt == irm_pkg::TGT_CBS |=> st_q.cbs == $past(st_q.wdata))
    else $error("committed burst limit not written");
  AST_WRITE_RATE: assert property ( // R9
    table_pending && !st_q.cmd[irm_pkg::CMD_DIR_BIT] &&
      tgt == irm_pkg::TGT_RATE && entry_ok(eidx) |=>
      st_q.rate[$past(eidx)] == $past(st_q.wdata))
    else $error("rate entry not written");
  AST_READ_EBS: assert property ( // R17
    table_pending && st_q.cmd[irm_pkg::CMD_DIR_BIT] &&
      tgt == irm_pkg::TGT_EBS |=> st_q.rdata == $past(st_q.ebs))
    else $error("read data not excess burst limit");
  // Read data is built at the setup edge, one cycle before pready
  AST_WDATA_UPPER: assert property ( // R13
    pready && idx == irm_pkg::IDX_WDATA |-> (prdata >> irm_pkg::DW) == 32'h0)
    else $error("write data upper bits not zero");
  AST_STS_PEND: assert property ( // R11
    pready && idx == irm_pkg::IDX_STS |->
      prdata[irm_pkg::STS_PEND_BIT] == $past(table_pending))
    else $error("status bit does not show pending");

  COV_CMD: cover property (cmd_wr ##1 table_pending ##1 !table_pending);
  COV_RAND: cover property (verdict_random && verdict_drop);
  COV_HARD: cover property (verdict_drop && !verdict_random);
  COV_PASS: cover property (verdict_valid && !verdict_drop && !verdict_random);
  COV_RDATA: cover property (pready && !pwrite && idx == irm_pkg::IDX_RDATA);
endmodule
`default_nettype wire

// ### verification/irm_pkt_src.sv
/*
 Packet source model standing on the ingress packet path.
 Assumes the bench calls send from one process only.
*/
`timescale 1ns/1ps
`default_nettype none
module irm_pkt_src (
  input  wire logic        pclk,
  input  wire logic        verdict_valid,
  input  wire logic        verdict_drop,
  input  wire logic        verdict_random,
  output var  logic        pkt_valid,
  output var  logic [4:0]  pkt_entry,
  output var  logic [15:0] pkt_len
);
  initial begin
    pkt_valid = 1'b0;
    pkt_entry = 5'h1f;
    pkt_len   = 16'hffff;
  end
  // ==========================================================
  // One request, verdict taken in the following cycle
  task automatic send(input logic [4:0] e, input logic [15:0] l,
                      output logic v, output logic d, output logic r);
    @(posedge pclk);
    pkt_valid <= 1'b1;
    pkt_entry <= e;
    pkt_len   <= l;
    @(posedge pclk);
    pkt_valid <= 1'b0;
    // Idle lines toggle so a stale value never looks valid
    pkt_entry <= ~e;
    pkt_len   <= ~l;
    #1;
    v = verdict_valid;
    d = verdict_drop;
    r = verdict_random;
  endtask
endmodule
`default_nettype wire

// ### verification/irm_rate_meter_tb.sv
/*
 Self-checking bench for the ingress rate meter table.
 Assumes irm_pkg and the packet source model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module irm_rate_meter_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr, pkt_len, cbs_m, ebs_m, wd;
  logic [31:0] pwdata, prdata, rd;
  logic        pkt_valid, table_pending, vv, vd, vr, er;
  logic        verdict_valid, verdict_drop, verdict_random;
  logic [4:0]  pkt_entry, x;
  logic [15:0] rate_m [24];
  int          errors, total_checks, seed, cyc, i, st;

  irm_rate_meter irm_rate_meter_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_entry(pkt_entry),
    .pkt_len(pkt_len), .verdict_valid(verdict_valid),
    .verdict_drop(verdict_drop), .verdict_random(verdict_random),
    .table_pending(table_pending));
  irm_pkt_src irm_pkt_src_inst (.pclk(pclk),
    .verdict_valid(verdict_valid), .verdict_drop(verdict_drop),
    .verdict_random(verdict_random), .pkt_valid(pkt_valid),
    .pkt_entry(pkt_entry), .pkt_len(pkt_len));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ==========================================================
  // Checking and bus tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [13:0] idx,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    apb(1'b1, irm_pkg::IDX_CMD, {24'h0, c});
    #1;
    chk({31'h0, table_pending}, 32'h1);
    @(posedge pclk);
    #1;
    chk({31'h0, table_pending}, 32'h0);
  endtask
  function automatic logic [15:0] exp_rd(input logic [1:0] t,
                                         input logic [4:0] n);
    if (t == irm_pkg::TGT_CBS) return cbs_m;
    if (t == irm_pkg::TGT_EBS) return ebs_m;
    if (t == irm_pkg::TGT_RATE && n < 5'h18) return rate_m[n];
    return 16'h0;
  endfunction
  task automatic tread(input logic [1:0] t, input logic [4:0] n);
    cmd({1'b1, t, n});
    apb(1'b0, irm_pkg::IDX_RDATA, 32'h0);
    chk(rd, {16'h0, exp_rd(t, n)});
  endtask
  task automatic twrite(input logic [1:0] t, input logic [4:0] n,
                        input logic [15:0] d);
    apb(1'b1, irm_pkg::IDX_WDATA, {16'h0, d});
    cmd({1'b0, t, n});
    if (t == irm_pkg::TGT_CBS) cbs_m = d;
    if (t == irm_pkg::TGT_EBS) ebs_m = d;
    if (t == irm_pkg::TGT_RATE) rate_m[n] = d;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h3e39;
    errors = 0;
    total_checks = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    for (i = 0; i < 24; i++) rate_m[i] = irm_pkg::RATE_RST;
    cbs_m = irm_pkg::BURST_RST;
    ebs_m = irm_pkg::BURST_RST;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, irm_pkg::IDX_STS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, irm_pkg::IDX_WDATA, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, irm_pkg::IDX_WDATA, 32'hffffffff);
    apb(1'b0, irm_pkg::IDX_WDATA, 32'h0);
    chk(rd, 32'h0000ffff);
    apb(1'b0, 14'h0000, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("register test done");
    tread(irm_pkg::TGT_CBS, 5'h0);
    tread(irm_pkg::TGT_EBS, 5'h0);
    tread(irm_pkg::TGT_RATE, 5'h0);
    tread(irm_pkg::TGT_RATE, 5'h17);
    tread(2'h0, 5'h0);
    twrite(2'h0, 5'h0, 16'h1234);
    tread(irm_pkg::TGT_CBS, 5'h0);
    tread(irm_pkg::TGT_RATE, 5'h1f);
    for (i = 0; i < 8; i++) begin
      x = 5'($unsigned($random(seed)) % 24);
      wd = 16'($random(seed));
      twrite(irm_pkg::TGT_RATE, x, wd);
      tread(irm_pkg::TGT_RATE, x);
    end
    // Excess limit kept above the largest packet sent
    twrite(irm_pkg::TGT_EBS, 5'h0, 16'h8000 | 16'($random(seed)));
    tread(irm_pkg::TGT_EBS, 5'h0);
    twrite(irm_pkg::TGT_CBS, 5'h0, 16'h0010);
    tread(irm_pkg::TGT_CBS, 5'h0);
    $display("table test done");
    // Fastest refill so the drained committed bucket visibly regrows
    twrite(irm_pkg::TGT_RATE, 5'h0, 16'h0);
    apb(1'b1, irm_pkg::IDX_CFG, 32'h1);
    irm_pkt_src_inst.send(5'h1, 16'h0100, vv, vd, vr);
    chk({vv, vd, vr}, 3'b100);
    st = 0;
    for (i = 0; i < 20; i++) begin
      irm_pkt_src_inst.send(5'h0, 16'h0600, vv, vd, vr);
      if (st == 0) chk({vv, vd, vr}, 3'b100);
      else if (st == 1) chk({vv, vr}, 2'b11);
      else chk({vv, vd, vr}, 3'b110);
      if (st == 0) st = 1;
      else if (st == 1 && vd === 1'b0) st = 2;
    end
    chk(st, 2);
    // Refilled bucket stops at the lowered committed limit
    repeat (64) @(posedge pclk);
    irm_pkt_src_inst.send(5'h0, 16'h0011, vv, vd, vr);
    chk({vv, vd | vr}, 2'b11);
    irm_pkt_src_inst.send(5'h0, 16'h0010, vv, vd, vr);
    chk({vv, vd, vr}, 3'b100);
    $display("metering test done");
    give_verdict();
  end
endmodule
`default_nettype wire
